// ===== logic/module_power_state_control.sv
// Device end: power-state controller driven by the power/wake key
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Host holds key low 5 s to power on
// - 5 s key low wakes deep sleep early
// - Power indicator high whenever powered, except deep sleep with power saving; unforceable
// - Host sees deep sleep only via indicator
// - Power saving turns aux supply off deep-sleep
// - Off: only clock runs, exits only to on
// - On: baseband powered, commands accepted immediately
// - Sleep: processor wakes intermittently, commands delayed
// - Deep sleep: baseband mostly down, event wakes
// - Clock runs off/deep sleep, lost without supply
// - Host drives key open drain only
// - Host confirms power-up via indicator high
// - Host keeps pins low while device off
// - 3 s key low while on powers off
// - Indicator low once power-off completes
module module_power_state_control #(
    parameter int unsigned ON_HOLD = power_state_pkg::ON_HOLD_CYC,
    parameter int unsigned OFF_HOLD = power_state_pkg::OFF_HOLD_CYC,
    parameter int unsigned DETACH = power_state_pkg::DETACH_CYC,
    parameter int unsigned BOOT = power_state_pkg::BOOT_CYC,
    parameter int unsigned SLP_PERIOD = power_state_pkg::SLEEP_PERIOD_CYC,
    parameter int unsigned SLP_AWAKE = power_state_pkg::SLEEP_AWAKE_CYC
) (
    // Clock and reset; reset stands for main supply present
    input wire logic clk,
    input wire logic rst_n,
    // Link to host
    power_key_if.device link,
    // Internal controls from firmware side
    input wire logic power_save_en,
    input wire logic sleep_req,
    input wire logic deep_req,
    input wire logic timer_wake,
    input wire logic cmd_valid,
    // Status toward internal logic
    output logic baseband_on,
    output logic cmd_ready,
    output logic rtc_run,
    output logic [31:0] rtc_count
);
    localparam int unsigned W = power_state_pkg::CNT_W;

    // Current power state
    power_state_pkg::dev_state_type state_q, state_d;
    // Key-low duration counter
    logic [W-1:0] hold_q, hold_d;
    // Boot, detach and sleep duty timer
    logic [W-1:0] tmr_q, tmr_d;
    // Real-time clock count
    logic [31:0] rtc_q, rtc_d;
    // Registered outputs
    logic pwr_q, pwr_d;
    logic aux_q, aux_d;
    logic bb_q, bb_d;
    // Key pressed level
    logic key_low;
    assign key_low = ~link.key_level;

    // Threshold test for the on-hold saturation and the boot, detach and sleep timers
    function automatic logic reached(input logic [W-1:0] c,
                                     input int unsigned lim);
        reached = (c >= W'(lim));
    endfunction : reached

    // Next-state logic
    always_comb
    begin
        state_d = state_q;
        tmr_d = tmr_q + W'(1);
        hold_d = key_low ? hold_q + W'(1) : '0;
        if (key_low && reached(hold_q, ON_HOLD))
        begin
            // Saturate only while held; a release must still clear
            hold_d = hold_q;
        end
        rtc_d = rtc_q + 32'h0000_0001;
        unique case (state_q)
            power_state_pkg::ST_OFF:
            begin
                if (key_low && hold_q == W'(ON_HOLD - 1))
                begin
                    state_d = power_state_pkg::ST_BOOT;
                    tmr_d = '0;
                end
            end
            power_state_pkg::ST_BOOT:
            begin
                // Wait for key release so the press is not reused
                if (reached(tmr_q, BOOT) && !key_low)
                begin
                    state_d = power_state_pkg::ST_ON;
                    tmr_d = '0;
                end
            end
            power_state_pkg::ST_ON:
            begin
                if (key_low && hold_q == W'(OFF_HOLD - 1))
                begin
                    state_d = power_state_pkg::ST_DOWN;
                    tmr_d = '0;
                end
                else if (deep_req)
                begin
                    state_d = power_state_pkg::ST_DEEP;
                end
                else if (sleep_req)
                begin
                    state_d = power_state_pkg::ST_SLEEP;
                    tmr_d = '0;
                end
            end
            power_state_pkg::ST_SLEEP:
            begin
                if (reached(tmr_q, SLP_PERIOD - 1))
                begin
                    tmr_d = '0;
                end
                if (key_low && hold_q == W'(OFF_HOLD - 1))
                begin
                    state_d = power_state_pkg::ST_DOWN;
                    tmr_d = '0;
                end
                else if (!sleep_req)
                begin
                    state_d = power_state_pkg::ST_ON;
                end
            end
            power_state_pkg::ST_DEEP:
            begin
                if ((key_low && hold_q == W'(ON_HOLD - 1)) || timer_wake)
                begin
                    state_d = power_state_pkg::ST_BOOT;
                    tmr_d = '0;
                end
            end
            power_state_pkg::ST_DOWN:
            begin
                // Detach then fall to off
                if (reached(tmr_q, DETACH) && !key_low)
                begin
                    state_d = power_state_pkg::ST_OFF;
                end
            end
            default:
            begin
                state_d = power_state_pkg::ST_OFF;
            end
        endcase
        // Hold idle timer from wrapping in waiting states
        if (state_q == power_state_pkg::ST_OFF
            || state_q == power_state_pkg::ST_ON
            || state_q == power_state_pkg::ST_DEEP)
        begin
            if (state_d == state_q)
            begin
                tmr_d = '0;
            end
        end
        // indicator high in every state but off, and deep sleep when saving
        pwr_d = (state_d != power_state_pkg::ST_OFF)
             && (state_d != power_state_pkg::ST_DEEP || !power_save_en);
        // aux off in deep sleep if saving
        aux_d = pwr_d;
        // baseband on when on, booting, detaching or in the sleep awake slice
        bb_d = (state_d == power_state_pkg::ST_ON)
            || (state_d == power_state_pkg::ST_BOOT)
            || (state_d == power_state_pkg::ST_DOWN)
            || (state_d == power_state_pkg::ST_SLEEP
                && tmr_d < W'(SLP_AWAKE));
    end

    // State registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= power_state_pkg::ST_OFF;
            hold_q <= '0;
            tmr_q <= '0;
            rtc_q <= 32'h0000_0000;
            pwr_q <= 1'b0;
            aux_q <= 1'b0;
            bb_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            hold_q <= hold_d;
            tmr_q <= tmr_d;
            rtc_q <= rtc_d;
            pwr_q <= pwr_d;
            aux_q <= aux_d;
            bb_q <= bb_d;
        end
    end

    // Outputs; the indicator has no command path at all
    assign link.power_on_indicator = pwr_q;
    assign link.aux_supply_out = aux_q;
    assign baseband_on = bb_q;
    // on accepts at once; sleep only awake
    assign cmd_ready = cmd_valid && bb_q
        && (state_q == power_state_pkg::ST_ON
            || state_q == power_state_pkg::ST_SLEEP);
    assign rtc_run = 1'b1;
    assign rtc_count = rtc_q;
endmodule : module_power_state_control
`default_nettype wire

// ===== include/power_state_pkg.sv
// Shared constants and types for the power-state controller and its host
package power_state_pkg;
    // Clock rate
    localparam int unsigned CLK_HZ = 25000000;
    // Key hold to power on or wake, seconds
    localparam int unsigned ON_HOLD_S = 5;
    // Key hold to power off, seconds
    localparam int unsigned OFF_HOLD_S = 3;
    // Derived cycle counts; least times, exact multiples here
    localparam int unsigned ON_HOLD_CYC = ON_HOLD_S * CLK_HZ;
    localparam int unsigned OFF_HOLD_CYC = OFF_HOLD_S * CLK_HZ;
    // Default orderly shutdown (detach) duration in cycles
    localparam int unsigned DETACH_CYC = 1000;
    // Default boot duration in cycles
    localparam int unsigned BOOT_CYC = 1000;
    // Default sleep duty period and awake slice in cycles
    localparam int unsigned SLEEP_PERIOD_CYC = 64;
    localparam int unsigned SLEEP_AWAKE_CYC = 8;
    // Counter width, enough for the longest hold
    localparam int unsigned CNT_W = 28;

    // Device operating states, one-hot
    typedef enum logic [5:0] {
        ST_OFF = 6'h01,
        ST_BOOT = 6'h02,
        ST_ON = 6'h04,
        ST_SLEEP = 6'h08,
        ST_DEEP = 6'h10,
        ST_DOWN = 6'h20
    } dev_state_type;

    // Host sequencer states, one-hot
    typedef enum logic [4:0] {
        H_IDLE = 5'h01,
        H_PRESS = 5'h02,
        H_WAIT_HI = 5'h04,
        H_WAIT_LO = 5'h08,
        H_DONE = 5'h10
    } host_state_type;
endpackage : power_state_pkg

// ===== include/power_key_if.sv
// Power/wake key and power monitor link between host and device
`timescale 1ns/1ps
`default_nettype none
interface power_key_if;
    // Host open-drain pull-down enable on the key line
    logic key_host_oe;
    // Key line level seen by both ends; internal pull-up gives high
    logic key_level;
    // Device power-on indication
    logic power_on_indicator;
    // Device auxiliary supply output
    logic aux_supply_out;
    // Internal pull-up: line stays high unless the host pulls it down
    assign key_level = ~key_host_oe;
    // Device end
    modport device (
        input key_level,
        output power_on_indicator,
        output aux_supply_out
    );
    // Host end
    modport host (
        output key_host_oe,
        input key_level,
        input power_on_indicator,
        input aux_supply_out
    );
endinterface : power_key_if
`default_nettype wire

// ===== logic/power_key_host.sv
// Host end: drives the open-drain power/wake key and watches the monitor
`timescale 1ns/1ps
`default_nettype none
module power_key_host #(
    parameter int unsigned ON_HOLD = power_state_pkg::ON_HOLD_CYC,
    parameter int unsigned OFF_HOLD = power_state_pkg::OFF_HOLD_CYC,
    parameter int unsigned MARGIN = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link to device
    power_key_if.host link,
    // User requests, one-cycle pulses
    input wire logic on_req,
    input wire logic off_req,
    input wire logic wake_req,
    // Status
    output logic busy,
    output logic done,
    output logic dev_powered,
    output logic pins_enable
);
    localparam int unsigned W = power_state_pkg::CNT_W;
    power_state_pkg::host_state_type st_q, st_d;
    logic [W-1:0] cnt_q, cnt_d;
    logic [W-1:0] lim_q, lim_d;
    logic want_hi_q, want_hi_d;
    logic oe_q, oe_d;
    logic done_q, done_d;

    // Sequencer next state
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q + W'(1);
        lim_d = lim_q;
        want_hi_d = want_hi_q;
        oe_d = 1'b0;
        done_d = 1'b0;
        unique case (st_q)
            power_state_pkg::H_IDLE:
            begin
                cnt_d = '0;
                if (on_req || wake_req)
                begin
                    st_d = power_state_pkg::H_PRESS;
                    // wake press as long as power-on
                    lim_d = W'(ON_HOLD + MARGIN);
                    want_hi_d = 1'b1;
                    oe_d = 1'b1;
                end
                else if (off_req)
                begin
                    st_d = power_state_pkg::H_PRESS;
                    lim_d = W'(OFF_HOLD + MARGIN);
                    want_hi_d = 1'b0;
                    oe_d = 1'b1;
                end
            end
            power_state_pkg::H_PRESS:
            begin
                oe_d = 1'b1;
                if (cnt_q >= lim_q)
                begin
                    oe_d = 1'b0;
                    cnt_d = '0;
                    st_d = want_hi_q ? power_state_pkg::H_WAIT_HI
                                     : power_state_pkg::H_WAIT_LO;
                end
            end
            power_state_pkg::H_WAIT_HI:
            begin
                if (link.power_on_indicator)
                begin
                    st_d = power_state_pkg::H_DONE;
                end
            end
            power_state_pkg::H_WAIT_LO:
            begin
                // off or deep sleep seen on indicator
                if (!link.power_on_indicator)
                begin
                    st_d = power_state_pkg::H_DONE;
                end
            end
            power_state_pkg::H_DONE:
            begin
                done_d = 1'b1;
                st_d = power_state_pkg::H_IDLE;
            end
            default:
            begin
                st_d = power_state_pkg::H_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= power_state_pkg::H_IDLE;
            cnt_q <= '0;
            lim_q <= '0;
            want_hi_q <= 1'b0;
            oe_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            lim_q <= lim_d;
            want_hi_q <= want_hi_d;
            oe_q <= oe_d;
            done_q <= done_d;
        end
    end

    assign link.key_host_oe = oe_q;
    assign busy = (st_q != power_state_pkg::H_IDLE);
    assign done = done_q;
    assign dev_powered = link.power_on_indicator;
    // pins low unless device up and stable
    assign pins_enable = link.power_on_indicator
        && (st_q == power_state_pkg::H_IDLE);
endmodule : power_key_host
`default_nettype wire

// ===== sim/power_key_monitor.sv
// Checker watching the key link between host and device ends
`timescale 1ns/1ps
`default_nettype none
module power_key_monitor #(
    parameter int unsigned ON_HOLD = 20,
    parameter int unsigned OFF_HOLD = 12,
    parameter int unsigned MARGIN = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link signals
    input wire logic key_host_oe,
    input wire logic key_level,
    input wire logic power_on_indicator,
    input wire logic aux_supply_out
);
    // Press lengths the host is expected to produce
    localparam int unsigned ON_LIM = ON_HOLD + MARGIN + 1;
    localparam int unsigned OFF_LIM = OFF_HOLD + MARGIN + 1;
    // Run lengths of key low and of host pull-down
    logic [31:0] low_q, low_d, oe_q, oe_d;
    // Next run lengths; saturating so a stuck key cannot wrap
    always_comb
    begin
        low_d = key_level ? 32'h0 : low_q + {31'h0, ~&low_q};
        oe_d = key_host_oe ? oe_q + {31'h0, ~&oe_q} : 32'h0;
    end
    // Run length registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_q <= 32'h0;
            oe_q <= 32'h0;
        end
        else
        begin
            low_q <= low_d;
            oe_q <= oe_d;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    aux_follows_a: assert property (
        aux_supply_out == power_on_indicator)
        else $error("aux supply differs from power indicator");
    open_drain_a: assert property (
        key_level == !key_host_oe)
        else $error("key line level not set by pull-down");
    // Timer wake has no key press, so only pressed rises are timed
    on_hold_a: assert property (
        $rose(power_on_indicator) && !key_level
        |-> low_q >= ON_HOLD - 1 && low_q <= ON_HOLD + 1)
        else $error("power-on not at the hold threshold");
    early_press_a: assert property (
        !power_on_indicator && !key_level && low_q + 2 < ON_HOLD
        |=> !power_on_indicator)
        else $error("power indicator rose on a short press");
    press_len_a: assert property (
        $fell(key_host_oe) |-> oe_q == ON_LIM || oe_q == OFF_LIM)
        else $error("host press length wrong");
    press_min_a: assert property (
        $rose(key_host_oe) |=> key_host_oe [*8])
        else $error("host press too short");
    boot_stays_a: assert property (
        $rose(power_on_indicator) |=> power_on_indicator [*8])
        else $error("power indicator dropped during boot");
    off_release_a: assert property (
        $fell(power_on_indicator) |-> $past(key_level))
        else $error("power indicator fell with key held");
endmodule : power_key_monitor
`default_nettype wire

// ===== sim/tb.sv
// Testbench joining host and device ends, plus a bare second device
`timescale 1ns/1ps
`default_nettype none
module tb;
    // Shortened hold counts
    localparam int unsigned ONH = 20;
    localparam int unsigned OFFH = 12;
    localparam int unsigned MRG = 2;
    // Clock, reset and stimulus
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pse = 1'b0, slp = 1'b0, dpr = 1'b0, twk = 1'b0, cmdv = 1'b0;
    logic on_r = 1'b0, off_r = 1'b0, wk_r = 1'b0;
    // Outputs seen
    logic bb, crdy, rrun, busy, done, dpw, pen;
    logic [31:0] rtc;
    int mismatches = 0, cmp_count = 0, n, t, i;
    // Main link, and a second one driven directly by the bench
    power_key_if link();
    power_key_if link2();
    initial link2.key_host_oe = 1'b0;
    module_power_state_control #(.ON_HOLD(ONH), .OFF_HOLD(OFFH),
        .DETACH(8), .BOOT(8)) module_power_state_control_inst (
        .clk(clk), .rst_n(rst_n), .link(link), .power_save_en(pse),
        .sleep_req(slp), .deep_req(dpr), .timer_wake(twk),
        .cmd_valid(cmdv), .baseband_on(bb), .cmd_ready(crdy),
        .rtc_run(rrun), .rtc_count(rtc));
    // Second device sees only bench presses
    module_power_state_control #(.ON_HOLD(ONH), .OFF_HOLD(OFFH),
        .DETACH(8), .BOOT(8)) module_power_state_control_inst2 (
        .clk(clk), .rst_n(rst_n), .link(link2), .power_save_en(pse),
        .sleep_req(slp), .deep_req(dpr), .timer_wake(twk),
        .cmd_valid(cmdv), .baseband_on(), .cmd_ready(),
        .rtc_run(), .rtc_count());
    power_key_host #(.ON_HOLD(ONH), .OFF_HOLD(OFFH), .MARGIN(MRG))
        power_key_host_inst (
        .clk(clk), .rst_n(rst_n), .link(link), .on_req(on_r),
        .off_req(off_r), .wake_req(wk_r), .busy(busy), .done(done),
        .dev_powered(dpw), .pins_enable(pen));
    power_key_monitor #(.ON_HOLD(ONH), .OFF_HOLD(OFFH), .MARGIN(MRG))
        power_key_monitor_inst (
        .clk(clk), .rst_n(rst_n), .key_host_oe(link.key_host_oe),
        .key_level(link.key_level),
        .power_on_indicator(link.power_on_indicator),
        .aux_supply_out(link.aux_supply_out));
    // Free-running clock
    initial
    begin
        forever #20 clk = ~clk;
    end
    // Single-bit compare
    task automatic chk(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("wrong value %s exp %b got %b", nm, e, g);
        end
    endtask : chk
    // Count compare
    task automatic chk32(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("wrong value %s exp %0d got %0d", nm, e, g);
        end
    endtask : chk32
    // One-cycle request: 0 on, 1 off, 2 wake, 3 deep, 4 timer
    task automatic pulse(input int k);
        @(posedge clk);
        on_r <= (k == 0);
        off_r <= (k == 1);
        wk_r <= (k == 2);
        dpr <= (k == 3);
        twk <= (k == 4);
        @(posedge clk);
        {on_r, off_r, wk_r, dpr, twk} <= 5'h00;
    endtask : pulse
    // Bounded wait for the host's done pulse
    task automatic wait_done();
        n = 0;
        while (done !== 1'b1 && n < 400)
        begin
            @(negedge clk);
            n++;
        end
        chk("done", 1'b1, done);
        @(negedge clk);
    endtask : wait_done
    // Bounded wait for the baseband to come up
    task automatic wait_bb();
        n = 0;
        while (bb !== 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        // Ride out boot so the next request meets the on state
        repeat (12) @(negedge clk);
    endtask : wait_bb
    // Press of k sampled cycles on the second link
    task automatic press2(input int k);
        @(posedge clk);
        link2.key_host_oe <= 1'b1;
        repeat (k) @(posedge clk);
        link2.key_host_oe <= 1'b0;
        repeat (4) @(negedge clk);
    endtask : press2
    // Clock counter advances one per cycle
    task automatic chk_rtc();
        t = rtc;
        repeat (10) @(negedge clk);
        chk32("rtc", t + 10, rtc);
    endtask : chk_rtc
    // Count report and verdict
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    // Watchdog against a hang, far past the expected run
    initial
    begin
        repeat (6000) @(posedge clk);
        mismatches++;
        print_verdict();
    end
    // Main sequence
    initial
    begin
        void'($urandom(32'h69636cf7));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk("ind", 1'b0, link.power_on_indicator);
        chk("bb", 1'b0, bb);
        chk("rtc_run", 1'b1, rrun);
        // Random short presses, then two near misses, then exact hold
        repeat (5)
        begin
            press2($urandom_range(ONH - 1, 1));
            chk("ind2", 1'b0, link2.power_on_indicator);
        end
        press2(ONH - 1);
        press2(ONH - 1);
        chk("ind2", 1'b0, link2.power_on_indicator);
        press2(ONH);
        chk("ind2", 1'b1, link2.power_on_indicator);
        pulse(0);
        wait_done();
        chk("powered", 1'b1, dpw);
        repeat (10) @(negedge clk);
        @(posedge clk);
        cmdv <= 1'b1;
        @(negedge clk);
        chk("bb", 1'b1, bb);
        chk("cmd_ready", 1'b1, crdy);
        chk("pins", 1'b1, pen);
        chk("aux", 1'b1, link.aux_supply_out);
        // Sleep duty: awake slice within one period
        @(posedge clk);
        slp <= 1'b1;
        repeat (3) @(negedge clk);
        t = 0;
        repeat (power_state_pkg::SLEEP_PERIOD_CYC)
        begin
            @(negedge clk);
            t += (bb === 1'b1);
        end
        chk32("awake", power_state_pkg::SLEEP_AWAKE_CYC, t);
        chk("ind", 1'b1, link.power_on_indicator);
        @(posedge clk);
        slp <= 1'b0;
        repeat (4) @(negedge clk);
        // Deep sleep with and without power saving, two wake paths
        for (i = 0; i < 4; i++)
        begin
            @(posedge clk);
            pse <= (i == 0) || (i > 1 && $urandom_range(1, 0) == 1);
            pulse(3);
            repeat (4) @(negedge clk);
            chk("ind", !pse, link.power_on_indicator);
            chk("aux", !pse, link.aux_supply_out);
            chk("bb", 1'b0, bb);
            chk("cmd_ready", 1'b0, crdy);
            if (i % 2 == 1)
                pulse(4);
            else
            begin
                pulse(2);
                wait_done();
            end
            wait_bb();
            chk("bb", 1'b1, bb);
        end
        // Orderly power-off, then requests in off are ignored
        pulse(1);
        wait_done();
        chk("ind", 1'b0, link.power_on_indicator);
        chk("bb", 1'b0, bb);
        chk("pins", 1'b0, pen);
        pulse(3);
        pulse(4);
        repeat (4) @(negedge clk);
        chk("ind", 1'b0, link.power_on_indicator);
        chk_rtc();
        // Supply loss clears the clock; power-on works again after
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(negedge clk);
        chk32("rtc", 32'h0, rtc);
        @(posedge clk);
        rst_n <= 1'b1;
        pulse(0);
        @(negedge clk);
        chk("busy", 1'b1, busy);
        wait_done();
        chk("powered", 1'b1, dpw);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
